/* File: pkg/epwm_pkg.sv */
package epwm_pkg;

  // register byte addresses (printed offsets are not word aligned: index * 4)
  localparam logic [11:0] EPWM_IDX_ASD1    = 12'hFBE;
  localparam logic [11:0] EPWM_IDX_ASD2    = 12'hFB8;
  localparam logic [11:0] EPWM_IDX_ASD3    = 12'hF19;
  localparam logic [13:0] EPWM_ADDR_ASD1   = {EPWM_IDX_ASD1, 2'b00};
  localparam logic [13:0] EPWM_ADDR_ASD2   = {EPWM_IDX_ASD2, 2'b00};
  localparam logic [13:0] EPWM_ADDR_ASD3   = {EPWM_IDX_ASD3, 2'b00};
  // own control/period/duty registers of the pwm core
  localparam logic [13:0] EPWM_ADDR_CTRL   = 14'h0000;
  localparam logic [13:0] EPWM_ADDR_PERIOD = 14'h0004;
  localparam logic [13:0] EPWM_ADDR_DUTY   = 14'h0008;

  // shutdown control field positions
  localparam int EPWM_F_EVT  = 7;
  localparam int EPWM_F_SRC  = 4;
  localparam int EPWM_F_AC   = 2;
  localparam int EPWM_F_BD   = 0;
  // control register field positions
  localparam int EPWM_F_EN   = 0;
  localparam int EPWM_F_MODE = 1;
  localparam int EPWM_F_POL  = 3;
  localparam int EPWM_F_ARST = 5;

  localparam logic [7:0]  EPWM_RST_ASD    = 8'h00;
  localparam logic [7:0]  EPWM_RST_CTRL   = 8'h00;
  localparam logic [9:0]  EPWM_RST_PERIOD = 10'h3FF;
  localparam logic [9:0]  EPWM_RST_DUTY   = 10'h000;
  localparam int          EPWM_RES        = 10;

  // output mode select
  typedef enum logic [1:0] {
    EPWM_M_SINGLE = 2'b00,
    EPWM_M_HALF   = 2'b01,
    EPWM_M_FWD    = 2'b10,
    EPWM_M_REV    = 2'b11
  } epwm_mode_t;

  // pair shutdown states
  localparam logic [1:0] EPWM_SD_LOW  = 2'b00;
  localparam logic [1:0] EPWM_SD_HIGH = 2'b01;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } epwm_pins_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [13:0] addr;
  } epwm_ahb_req_t;

endpackage

/* File: rtl/epwm_core.sv */
`timescale 1ns/1ps
// period counter and duty compare; starts only at a period boundary
module epwm_core
  import epwm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic       run,
  input  wire logic [9:0] period,
  input  wire logic [9:0] duty,
  // result
  output logic            raw,
  output logic            wrap
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       raw;
  } epwm_core_st_t;

  epwm_core_st_t st_r;
  epwm_core_st_t st_nxt;

  // counter always runs so a period boundary exists when run rises
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt >= period) begin
      st_nxt.cnt = 10'h000;
    end else begin
      st_nxt.cnt = st_r.cnt + 10'h001;
    end
    st_nxt.raw = run && (st_nxt.cnt < duty);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign raw  = st_r.raw;
  assign wrap = (st_r.cnt >= period);

endmodule

/* File: rtl/epwm_steer.sv */
`timescale 1ns/1ps
// maps the raw waveform onto four pins by mode and polarity
module epwm_steer
  import epwm_pkg::*;
(
  // waveform
  input  wire logic       raw,
  input  wire logic [1:0] mode,
  input  wire logic [1:0] pol,
  // pins before shutdown
  output epwm_pins_t      pins
);

  logic pa;
  logic pb;

  // pol[0] inverts a/c, pol[1] inverts b/d
  assign pa = raw ^ pol[0];
  assign pb = raw ^ pol[1];

  always_comb begin
    pins.o  = 4'h0;
    pins.oe = 4'h0;
    unique case (epwm_mode_t'(mode))
      EPWM_M_SINGLE: begin
        pins.o  = {3'h0, pa};
        pins.oe = 4'h1;
      end
      EPWM_M_HALF: begin
        pins.o  = {2'h0, ~pb, pa};
        pins.oe = 4'h3;
      end
      // forward: a steady on, d modulated
      EPWM_M_FWD: begin
        pins.o  = {pb, 1'b0 ^ pol[0], 1'b0 ^ pol[1], ~pol[0]};
        pins.oe = 4'hF;
      end
      // reverse: c steady on, b modulated
      EPWM_M_REV: begin
        pins.o  = {1'b0 ^ pol[1], ~pol[0], pb, 1'b0 ^ pol[0]};
        pins.oe = 4'hF;
      end
    endcase
  end

endmodule

/* File: rtl/epwm_top.sv */
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - four output pins, duty resolution up to 10 bits
// - single, half-bridge, full forward and full reverse output modes
// - software selects active polarity of output pins
// - on first enable, waveform waits for a new period
// - shutdown sets event flag; held until firmware or auto-restart clears
// - shutdown forces enabled pins to shutdown state at the next clock edge
// - pins grouped a/c and b/d, each low, high or tri-state
// - 3-bit source field selects comparators and fault pin low
// - a/c field: 00 low, 01 high, 1x tri-state
// - b/d field: 00 low, 01 high, 1x tri-state
// - bit 7 reads 1 while outputs are shut down
// - shutdown is level sensitive, persists while source active
// - writes to event flag ignored while condition present
// - after restart waveform resumes at next period start
// - pins unused by the mode are released
module epwm_top
  import epwm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // shutdown sources
  input  wire logic        comparator1_result,
  input  wire logic        comparator2_result,
  input  wire logic        fault_input_pin,
  // pwm pins
  output logic             pwm_out_a,
  output logic             pwm_out_b,
  output logic             pwm_out_c,
  output logic             pwm_out_d,
  output logic [3:0]       pwm_oe
);

  typedef struct packed {
    epwm_ahb_req_t req;
    logic [7:0]    asd;
    logic [7:0]    ctrl;
    logic [9:0]    period;
    logic [9:0]    duty;
    logic          run;
    logic [31:0]   rdata;
    epwm_pins_t    pins;
  } epwm_st_t;

  epwm_st_t   st_r;
  epwm_st_t   st_nxt;
  logic       raw;
  logic       wrap;
  logic       cond;
  logic [2:0] src;
  epwm_pins_t norm;
  epwm_pins_t shut;
  logic       want;

  assign src = st_r.asd[EPWM_F_SRC +: 3];

  // level-sensitive condition, decoded bit per source
  assign cond = (src[0] & comparator1_result) |
                (src[1] & comparator2_result) |
                (src[2] & ~fault_input_pin);

  assign want = st_r.ctrl[EPWM_F_EN] & ~st_r.asd[EPWM_F_EVT] & ~cond;

  epwm_core u_core (
    .clk    (clk),
    .rstn   (rstn),
    .run    (st_r.run),
    .period (st_r.period),
    .duty   (st_r.duty),
    .raw    (raw),
    .wrap   (wrap)
  );

  epwm_steer u_steer (
    .raw  (raw),
    .mode (st_r.ctrl[EPWM_F_MODE +: 2]),
    .pol  (st_r.ctrl[EPWM_F_POL +: 2]),
    .pins (norm)
  );

  // shutdown pin image per pair; 1x releases the pair
  always_comb begin
    shut = norm;
    shut.o[0]  = (st_r.asd[EPWM_F_AC +: 2] == EPWM_SD_HIGH);
    shut.o[2]  = shut.o[0];
    shut.oe[0] = norm.oe[0] & ~st_r.asd[EPWM_F_AC + 1];
    shut.oe[2] = norm.oe[2] & ~st_r.asd[EPWM_F_AC + 1];
    shut.o[1]  = (st_r.asd[EPWM_F_BD +: 2] == EPWM_SD_HIGH);
    shut.o[3]  = shut.o[1];
    shut.oe[1] = norm.oe[1] & ~st_r.asd[EPWM_F_BD + 1];
    shut.oe[3] = norm.oe[3] & ~st_r.asd[EPWM_F_BD + 1];
  end

  logic wr_hit;
  logic [13:0] wa;
  assign wr_hit = st_r.req.sel & st_r.req.wr;
  assign wa     = st_r.req.addr;

  // bus decode, flag and run control
  always_comb begin
    st_nxt = st_r;
    st_nxt.req.sel  = hsel & hready & htrans[1];
    st_nxt.req.wr   = hwrite;
    st_nxt.req.addr = haddr[13:0];
    // write data phase
    if (wr_hit) begin
      if (wa == EPWM_ADDR_ASD1 || wa == EPWM_ADDR_ASD2 || wa == EPWM_ADDR_ASD3) begin
        st_nxt.asd[6:0] = hwdata[6:0];
        if (!cond) begin
          st_nxt.asd[EPWM_F_EVT] = hwdata[EPWM_F_EVT];
        end
      end else if (wa == EPWM_ADDR_CTRL) begin
        st_nxt.ctrl = hwdata[7:0];
      end else if (wa == EPWM_ADDR_PERIOD) begin
        st_nxt.period = hwdata[9:0];
      end else if (wa == EPWM_ADDR_DUTY) begin
        st_nxt.duty = hwdata[9:0];
      end
    end
    // auto-restart clears the flag once the source has gone
    if (!cond && st_r.ctrl[EPWM_F_ARST]) begin
      st_nxt.asd[EPWM_F_EVT] = 1'b0;
    end
    // hardware set wins over any clear
    if (cond) begin
      st_nxt.asd[EPWM_F_EVT] = 1'b1;
    end
    // start only at a period boundary; stop at once, also when software sets the flag
    if (!want || st_nxt.asd[EPWM_F_EVT]) begin
      st_nxt.run = 1'b0;
    end else if (wrap) begin
      st_nxt.run = 1'b1;
    end
    // read data for the next data phase
    st_nxt.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[13:0])
        EPWM_ADDR_ASD1, EPWM_ADDR_ASD2, EPWM_ADDR_ASD3:
          st_nxt.rdata = {24'h00_0000, st_nxt.asd};
        EPWM_ADDR_CTRL:   st_nxt.rdata = {24'h00_0000, st_nxt.ctrl};
        EPWM_ADDR_PERIOD: st_nxt.rdata = {22'h00_0000, st_nxt.period};
        EPWM_ADDR_DUTY:   st_nxt.rdata = {22'h00_0000, st_nxt.duty};
        default:          st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.pins = (st_nxt.asd[EPWM_F_EVT]) ? shut : norm;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r        <= '0;
      st_r.asd    <= EPWM_RST_ASD;
      st_r.ctrl   <= EPWM_RST_CTRL;
      st_r.period <= EPWM_RST_PERIOD;
      st_r.duty   <= EPWM_RST_DUTY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // registered pins; the flag is set within one cycle of cond
  assign pwm_out_a = st_r.pins.o[0];
  assign pwm_out_b = st_r.pins.o[1];
  assign pwm_out_c = st_r.pins.o[2];
  assign pwm_out_d = st_r.pins.o[3];
  assign pwm_oe    = st_r.pins.oe;
  assign hrdata    = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // checks
  chk_flag_sets: assert property (
    @(posedge clk) disable iff (!rstn)
    cond |=> st_r.asd[EPWM_F_EVT]) else $error("flag not set on shutdown");
  chk_no_run_sd: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.asd[EPWM_F_EVT] |-> !st_r.run) else $error("running while shut down");
  chk_start_wrap: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(st_r.run) |-> $past(wrap)) else $error("start off period boundary");
  chk_hold_write: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_hit && cond) |=> st_r.asd[EPWM_F_EVT]) else $error("flag cleared in shutdown");
  chk_autoclear: assert property (
    @(posedge clk) disable iff (!rstn)
    (!cond && st_r.ctrl[EPWM_F_ARST] && !wr_hit) |=> !st_r.asd[EPWM_F_EVT])
    else $error("auto restart failed");
  // pins b, c and d stay released in single mode, shut down or not
  chk_single_oe: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_r.ctrl[EPWM_F_MODE +: 2] == 2'b00) |=> (pwm_oe[3:1] == 3'h0))
    else $error("unused pin driven in single mode");
  chk_pair_ac: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_r.asd[EPWM_F_EVT] && st_r.asd[3]) |-> (pwm_oe[0] == 1'b0 || $changed(st_r.asd)))
    else $error("a/c not released");
  chk_pair_bd: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_r.asd[EPWM_F_EVT] && st_r.asd[1]) |-> (pwm_oe[1] == 1'b0 || $changed(st_r.asd)))
    else $error("b/d not released");

endmodule

/* File: testbench/epwm_bridge.sv */
`timescale 1ns/1ps
// gate driver of the external bridge; a released gate input sits on its pull-down
module epwm_bridge
  import epwm_pkg::*;
(
  // gate inputs from the block
  input  wire logic [3:0] drv,
  input  wire logic [3:0] en,
  // gate levels seen by the power stage
  output logic [3:0]      pad
);
  // pins the block does not drive read as the pull-down level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad[i] = en[i] ? drv[i] : 1'b0;
    end
  end
endmodule

/* File: testbench/epwm_top_bench.sv */
`timescale 1ns/1ps
module epwm_top_bench
  import epwm_pkg::*;
;
  logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, c1 = 0, c2 = 0, flt_n = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, oa, ob, oc, od;
  logic [3:0]  oe, pad;
  int          bad_count = 0, checked = 0, cyc = 0;

  always #25 clk = ~clk;

  epwm_top i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comparator1_result(c1),
    .comparator2_result(c2), .fault_input_pin(flt_n), .pwm_out_a(oa), .pwm_out_b(ob),
    .pwm_out_c(oc), .pwm_out_d(od), .pwm_oe(oe));
  epwm_bridge i_brg (.drv({od, oc, ob, oa}), .en(oe), .pad(pad));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard well above the fewer than seven hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // one ahb-lite single transfer; called just after a rising edge
  task automatic xfer(bit w, logic [13:0] a, logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
  endtask

  // reset values, register aliases and an unmapped place
  task automatic s_regs();
    xfer(0, EPWM_ADDR_ASD1, 0); chk("asd1", 32'h0, rd);
    chk("resp", 32'h0, 32'(hresp));
    xfer(0, EPWM_ADDR_CTRL, 0); chk("ctrl", 32'h0, rd);
    xfer(0, EPWM_ADDR_PERIOD, 0); chk("per", 32'h3FF, rd);
    xfer(0, 14'h0100, 0); chk("unmapped", 32'h0, rd);
    xfer(1, EPWM_ADDR_ASD3, 32'h2A);
    xfer(0, EPWM_ADDR_ASD2, 0); chk("alias", 32'h2A, rd);
    xfer(1, EPWM_ADDR_PERIOD, 32'h4);
  endtask

  // enables per mode: unused pins released
  task automatic s_modes();
    logic [3:0] e[4] = '{4'h1, 4'h3, 4'hF, 4'hF};
    // levels at zero duty: half drives b as complement, full bridges hold one leg on
    logic [3:0] p[4] = '{4'h0, 4'h2, 4'h1, 4'h4};
    for (int m = 0; m < 4; m++) begin
      xfer(1, EPWM_ADDR_CTRL, 32'(m * 2 + 1));
      wait_n(12);
      chk("oe", 32'(e[m]), 32'(oe));
      chk("pad", 32'(p[m]), 32'(pad));
    end
  endtask

  // zero duty in single mode, with and without inversion
  task automatic s_pol();
    int hi;
    hi = 0;
    xfer(1, EPWM_ADDR_CTRL, 32'h1);
    wait_n(12);
    chk("a_plain", 32'h0, 32'(oa));
    xfer(1, EPWM_ADDR_CTRL, 32'h9);
    wait_n(12);
    chk("a_inv", 32'h1, 32'(oa));
    // duty 2 of a five-count period: two high cycles in every five
    xfer(1, EPWM_ADDR_DUTY, 32'h2);
    xfer(0, EPWM_ADDR_DUTY, 0); chk("duty", 32'h2, rd);
    xfer(1, EPWM_ADDR_CTRL, 32'h1);
    wait_n(12);
    repeat (10) begin
      @(posedge clk);
      hi += int'(oa);
    end
    chk("high", 32'h4, 32'(hi));
  endtask

  // every source code against each input alone; forward bridge holds a high
  task automatic s_src();
    xfer(1, EPWM_ADDR_CTRL, 32'h5);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        xfer(1, EPWM_ADDR_ASD1, 32'(s << 4));
        c1 <= (k == 0);
        c2 <= (k == 1);
        flt_n <= (k != 2);
        wait_n(3);
        chk("pad_a", 32'(!s[k]), 32'(pad[0]));
        xfer(0, EPWM_ADDR_ASD1, 0);
        chk("flag", 32'(s[k]), 32'(rd[7]));
        c1 <= 0;
        c2 <= 0;
        flt_n <= 1;
        xfer(1, EPWM_ADDR_ASD1, 32'h0);
        wait_n(12);
        chk("resume", 32'h1, 32'(pad[0]));
      end
    end
  endtask

  // clear ignored while active; pair states; auto restart
  task automatic s_hold();
    xfer(1, EPWM_ADDR_ASD1, 32'h16);
    c1 <= 1;
    wait_n(3);
    chk("ac_high", 32'h5, 32'({pad[2], 1'b0, pad[0]}));
    chk("bd_oe", 32'h0, 32'({oe[3], oe[1]}));
    xfer(1, EPWM_ADDR_ASD1, 32'h16);
    xfer(0, EPWM_ADDR_ASD1, 0);
    chk("held", 32'h96, rd);
    c1 <= 0;
    xfer(1, EPWM_ADDR_CTRL, 32'h25);
    wait_n(3);
    xfer(0, EPWM_ADDR_ASD1, 0);
    chk("auto", 32'h16, rd);
    // both pairs tri-state in shutdown, back on after auto restart
    xfer(1, EPWM_ADDR_ASD1, 32'h1A);
    c1 <= 1;
    wait_n(3);
    chk("ac_oe", 32'h0, 32'(oe));
    c1 <= 0;
    wait_n(3);
    chk("oe_back", 32'hF, 32'(oe));
  endtask

  initial begin
    wait_n(5);
    rstn <= 1;
    @(posedge clk);
    s_regs();
    s_modes();
    s_pol();
    s_src();
    s_hold();
    summarize();
  end
endmodule
